/* File: core/alpha_defines.svh */
`ifndef ALPHA_DEFINES_SVH
`define ALPHA_DEFINES_SVH

// ----------------------------------------------------------------
// Leading byte markers of the 16-bit alpha schemes
// ----------------------------------------------------------------
`define ALPHA_MARK_DIRECT 8'h80
`define ALPHA_MARK_HALF8 8'h81
`define ALPHA_MARK_HALF16 8'h82

// ----------------------------------------------------------------
// Byte and code point layout
// ----------------------------------------------------------------
`define ALPHA_FILL_BYTE 8'hFF
`define ALPHA_FILL_PAIR 16'hFFFF
`define ALPHA_TOP_BIT 7
`define ALPHA_LOW7_MSB 6
`define ALPHA_COUNT_ZERO 8'h00
`define ALPHA_COUNT_ONE 8'h01
`define ALPHA_COUNT_STEP 8'h01
`define ALPHA_CODE_ZERO 16'h0000

// ----------------------------------------------------------------
// Buffering
// ----------------------------------------------------------------
`define ALPHA_FIFO_DEPTH 4

`endif

/* File: core/alpha_pkg.sv */
package alpha_pkg;

    // One byte of an alpha field with its framing marks
    typedef struct packed {
        logic first;
        logic last;
        logic [7:0] data;
    } field_beat_t;

    typedef enum logic [1:0] {
        SCHEME_DEFAULT,
        SCHEME_DIRECT,
        SCHEME_HALF8,
        SCHEME_HALF16
    } scheme_t;

    // One decoded character
    typedef struct packed {
        logic [15:0] code;
        logic is_default;
        scheme_t scheme;
    } alpha_char_t;

    typedef enum {
        ST_HEADER,
        ST_COUNT,
        ST_PTR_HI,
        ST_PTR_LO,
        ST_CHARS,
        ST_RAW_HI,
        ST_RAW_LO,
        ST_PLAIN,
        ST_SKIP
    } dec_state_t;

endpackage

/* File: core/alpha_byte_fifo.sv */
`timescale 1ns/100ps
`include "alpha_defines.svh"

module alpha_byte_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = `ALPHA_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Filling side
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    output logic wr_ready,
    // Draining side
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data,
    input wire logic rd_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
    logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
    logic [CW-1:0] count_ff, nxt_count;
    logic ready_ff, nxt_ready;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] step_ptr(input logic [AW-1:0] ptr);
        step_ptr = (ptr == AW'(DEPTH - 1)) ? '0 : ptr + AW'(1);
    endfunction

    assign push = wr_valid & ready_ff;
    assign pop = rd_valid & rd_ready;
    assign wr_ready = ready_ff;
    assign rd_valid = (count_ff != '0);
    assign rd_data = mem[rd_ptr_ff];

    // ----------------------------------------------------------------
    // Pointers and fill level
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_wr_ptr = push ? step_ptr(wr_ptr_ff) : wr_ptr_ff;
        nxt_rd_ptr = pop ? step_ptr(rd_ptr_ff) : rd_ptr_ff;
        nxt_count = count_ff;
        if (push && !pop)
        begin
            nxt_count = count_ff + CW'(1);
        end
        else if (pop && !push)
        begin
            nxt_count = count_ff - CW'(1);
        end
        // Ready is registered so the filling side never sees a combinational path
        nxt_ready = (nxt_count != CW'(DEPTH));
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            ready_ff <= 1'b0;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            ready_ff <= nxt_ready;
        end
    end

    // Storage needs no reset; empty slots are never read out as valid
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_ptr_ff] <= wr_data;
        end
    end

endmodule // alpha_byte_fifo

/* File: core/ucs2_alpha_field_decoder.sv */
`timescale 1ns/100ps
`include "alpha_defines.svh"

// Functional notes
// - Leading byte 80h makes every following byte pair before an FFFFh pair one code point, first byte high.
// - Leading byte 81h makes the second byte the number of characters.
// - In the 81h scheme the third byte sits above seven zero bits to form the base pointer.
// - In the 81h scheme counted bytes from the fourth on with top bit clear are default characters; bytes past the count are skipped.
// - A character byte with top bit set adds its low seven bits to the base pointer.
// - Leading byte 82h gives a count in byte two and a full pointer in bytes three and four.
// - In the 82h scheme characters start at byte five and decode as in the 81h scheme.
// - All three schemes are decoded, which covers both small and large character sets.
module ucs2_alpha_field_decoder
    import alpha_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Field bytes from the record reader
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    input wire logic in_first,
    input wire logic in_last,
    output logic in_ready,
    // Decoded characters to the consumer
    output logic out_valid,
    output alpha_char_t out_char,
    input wire logic out_ready,
    // Status
    output logic busy
);
    field_beat_t wr_beat;
    field_beat_t beat;
    logic beat_valid;
    logic take;

    dec_state_t state_ff, nxt_state;
    logic [15:0] base_ff, nxt_base;
    logic [7:0] count_ff, nxt_count;
    logic [7:0] high_ff, nxt_high;
    scheme_t scheme_ff, nxt_scheme;
    logic out_valid_ff, nxt_out_valid;
    alpha_char_t out_char_ff, nxt_out_char;
    logic busy_ff, nxt_busy;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic alpha_char_t half_page_char(
        input logic [7:0] b,
        input logic [15:0] base,
        input scheme_t sch
    );
        alpha_char_t c;
        c.scheme = sch;
        if (b[`ALPHA_TOP_BIT])
        begin
            c.code = base + {9'h000, b[`ALPHA_LOW7_MSB:0]};
            c.is_default = 1'b0;
        end
        else
        begin
            c.code = {9'h000, b[`ALPHA_LOW7_MSB:0]};
            c.is_default = 1'b1;
        end
        return c;
    endfunction

    function automatic alpha_char_t plain_char(
        input logic [15:0] code,
        input logic dflt,
        input scheme_t sch
    );
        alpha_char_t c;
        c.code = code;
        c.is_default = dflt;
        c.scheme = sch;
        return c;
    endfunction

    // ----------------------------------------------------------------
    // Input buffering
    // ----------------------------------------------------------------
    assign wr_beat.first = in_first;
    assign wr_beat.last = in_last;
    assign wr_beat.data = in_data;

    alpha_byte_fifo #(
        .WIDTH($bits(field_beat_t)),
        .DEPTH(`ALPHA_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .wr_valid(in_valid),
        .wr_data(wr_beat),
        .wr_ready(in_ready),
        .rd_valid(beat_valid),
        .rd_data(beat),
        .rd_ready(take)
    );

    // A byte is consumed only when the output slot is free, so a stalled
    // consumer backs up through the FIFO to the record reader
    assign take = beat_valid & (~out_valid_ff | out_ready);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_base = base_ff;
        nxt_count = count_ff;
        nxt_high = high_ff;
        nxt_scheme = scheme_ff;
        nxt_out_valid = out_valid_ff & ~out_ready;
        nxt_out_char = out_char_ff;
        nxt_busy = busy_ff;
        if (take)
        begin
            // A first-byte mark always restarts, recovering from a cut field
            if (beat.first || state_ff == ST_HEADER)
            begin
                nxt_busy = 1'b1;
                case (beat.data)
                    `ALPHA_MARK_DIRECT:
                    begin
                        nxt_scheme = SCHEME_DIRECT;
                        nxt_state = ST_RAW_HI;
                    end
                    `ALPHA_MARK_HALF8:
                    begin
                        nxt_scheme = SCHEME_HALF8;
                        nxt_state = ST_COUNT;
                    end
                    `ALPHA_MARK_HALF16:
                    begin
                        nxt_scheme = SCHEME_HALF16;
                        nxt_state = ST_COUNT;
                    end
                    default:
                    begin
                        // Unmarked record: default alphabet bytes, FFh is filler
                        nxt_scheme = SCHEME_DEFAULT;
                        nxt_state = ST_PLAIN;
                        if (beat.data != `ALPHA_FILL_BYTE)
                        begin
                            nxt_out_valid = 1'b1;
                            nxt_out_char = plain_char({9'h000, beat.data[`ALPHA_LOW7_MSB:0]},
                                1'b1, SCHEME_DEFAULT);
                        end
                    end
                endcase
            end
            else
            begin
                case (state_ff)
                    ST_COUNT:
                    begin
                        nxt_count = beat.data;
                        nxt_state = ST_PTR_HI;
                    end
                    ST_PTR_HI:
                    begin
                        if (scheme_ff == SCHEME_HALF8)
                        begin
                            nxt_base = {1'b0, beat.data, 7'h00};
                            nxt_state = (count_ff == `ALPHA_COUNT_ZERO) ? ST_SKIP : ST_CHARS;
                        end
                        else
                        begin
                            nxt_base = {beat.data, base_ff[7:0]};
                            nxt_state = ST_PTR_LO;
                        end
                    end
                    ST_PTR_LO:
                    begin
                        nxt_base = {base_ff[15:8], beat.data};
                        // Characters begin with the next byte, the fifth
                        nxt_state = (count_ff == `ALPHA_COUNT_ZERO) ? ST_SKIP : ST_CHARS;
                    end
                    ST_CHARS:
                    begin
                        nxt_out_valid = 1'b1;
                        nxt_out_char = half_page_char(beat.data, base_ff, scheme_ff);
                        nxt_count = count_ff - `ALPHA_COUNT_STEP;
                        if (count_ff == `ALPHA_COUNT_ONE)
                        begin
                            nxt_state = ST_SKIP;
                        end
                    end
                    ST_RAW_HI:
                    begin
                        nxt_high = beat.data;
                        nxt_state = ST_RAW_LO;
                    end
                    ST_RAW_LO:
                    begin
                        // A pair of filler bytes ends the characters; a lone odd
                        // byte before the field end is dropped as unusable
                        if ({high_ff, beat.data} == `ALPHA_FILL_PAIR)
                        begin
                            nxt_state = ST_SKIP;
                        end
                        else
                        begin
                            nxt_out_valid = 1'b1;
                            nxt_out_char = plain_char({high_ff, beat.data}, 1'b0,
                                SCHEME_DIRECT);
                            nxt_state = ST_RAW_HI;
                        end
                    end
                    ST_PLAIN:
                    begin
                        if (beat.data != `ALPHA_FILL_BYTE)
                        begin
                            nxt_out_valid = 1'b1;
                            nxt_out_char = plain_char({9'h000, beat.data[`ALPHA_LOW7_MSB:0]},
                                1'b1, SCHEME_DEFAULT);
                        end
                    end
                    ST_SKIP:
                    begin
                        nxt_state = ST_SKIP;
                    end
                    default:
                    begin
                        nxt_state = ST_HEADER;
                    end
                endcase
            end
            if (beat.last)
            begin
                nxt_state = ST_HEADER;
                nxt_busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= ST_HEADER;
            base_ff <= `ALPHA_CODE_ZERO;
            count_ff <= `ALPHA_COUNT_ZERO;
            high_ff <= `ALPHA_COUNT_ZERO;
            scheme_ff <= SCHEME_DEFAULT;
            out_valid_ff <= 1'b0;
            out_char_ff <= '0;
            busy_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            base_ff <= nxt_base;
            count_ff <= nxt_count;
            high_ff <= nxt_high;
            scheme_ff <= nxt_scheme;
            out_valid_ff <= nxt_out_valid;
            out_char_ff <= nxt_out_char;
            busy_ff <= nxt_busy;
        end
    end

    assign out_valid = out_valid_ff;
    assign out_char = out_char_ff;
    assign busy = busy_ff;

endmodule // ucs2_alpha_field_decoder

/* File: sim/alpha_decoder_monitor.sv */
`timescale 1ns/100ps
module alpha_decoder_monitor
    import alpha_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Field bytes
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    input wire logic in_first,
    input wire logic in_last,
    input wire logic in_ready,
    // Characters and status
    input wire logic out_valid,
    input wire alpha_char_t out_char,
    input wire logic out_ready,
    input wire logic busy
);
    logic seen_ff;
    logic nxt_seen;

    // Nothing may come out before a field has started
    always_comb nxt_seen = seen_ff | (in_valid & in_ready & in_first);
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            seen_ff <= 1'b0;
        else
            seen_ff <= nxt_seen;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence stalled_s;
        out_valid && !out_ready;
    endsequence

    reset_quiet_a: assert property (disable iff (1'b0) rst |-> !out_valid && !in_ready && !busy
        && out_char == '0) else $error("outputs not quiet in reset");
    char_hold_a: assert property (stalled_s |=> out_valid && $stable(out_char))
        else $error("stalled character changed");
    first_seen_a: assert property (out_valid |-> seen_ff)
        else $error("character before any field start");
    dflt_shape_a: assert property (
        out_valid && out_char.is_default |-> out_char.code[15:7] == 9'h000)
        else $error("default character wider than seven bits");
    direct_wide_a: assert property (
        out_valid && out_char.scheme == SCHEME_DIRECT |-> !out_char.is_default)
        else $error("direct character flagged default");
    direct_fill_a: assert property (
        out_valid && out_char.scheme == SCHEME_DIRECT |-> out_char.code != 16'hFFFF)
        else $error("fill pair emitted as character");
    plain_dflt_a: assert property (
        out_valid && out_char.scheme == SCHEME_DEFAULT |-> out_char.is_default)
        else $error("unmarked field gave wide character");
    half8_base_a: assert property (
        out_valid && out_char.scheme == SCHEME_HALF8 |-> !out_char.code[15])
        else $error("half page pointer has top bit set");
endmodule // alpha_decoder_monitor

bind ucs2_alpha_field_decoder alpha_decoder_monitor mon_u (.clock(clock), .rst(rst),
    .in_valid(in_valid), .in_data(in_data), .in_first(in_first), .in_last(in_last),
    .in_ready(in_ready), .out_valid(out_valid), .out_char(out_char), .out_ready(out_ready),
    .busy(busy));

/* File: sim/alpha_field_reader.sv */
`timescale 1ns/100ps
module alpha_field_reader
    import alpha_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Byte stream
    output logic in_valid,
    output logic [7:0] in_data,
    output logic in_first,
    output logic in_last,
    input wire logic in_ready
);
    field_beat_t q[$];
    field_beat_t b;
    int pseed = 32'h0000BEEF;

    initial
    begin
        in_valid = 1'b0;
        in_data = 8'h00;
        in_first = 1'b0;
        in_last = 1'b0;
    end

    // Offer held until taken; idle lines toggle so stale bytes never look valid
    always @(posedge clock or posedge rst)
    begin
        if (rst)
            in_valid <= 1'b0;
        else if (!in_valid || in_ready)
        begin
            if (q.size() > 0 && ($random(pseed) & 3) != 0)
            begin
                b = q.pop_front();
                in_valid <= 1'b1;
                {in_first, in_last, in_data} <= b;
            end
            else
            begin
                in_valid <= 1'b0;
                {in_first, in_last, in_data} <= ~{in_first, in_last, in_data};
            end
        end
    end
endmodule // alpha_field_reader

/* File: sim/test_ucs2_alpha_field_decoder.sv */
`timescale 1ns/100ps
module test_ucs2_alpha_field_decoder
    import alpha_pkg::*;
;
    typedef logic [7:0] byte_q_t[$];
    logic clock, rst, in_valid, in_first, in_last, in_ready, out_valid, out_ready, busy;
    logic [7:0] in_data;
    alpha_char_t out_char;
    alpha_char_t got_q[$];
    alpha_char_t exp_q[$];
    int fail_count = 0;
    int checks = 0;
    int seed = 32'hae6567d6;
    logic stall_en = 1'b0;

    alpha_field_reader reader_u (.clock(clock), .rst(rst), .in_valid(in_valid),
        .in_data(in_data), .in_first(in_first), .in_last(in_last), .in_ready(in_ready));
    ucs2_alpha_field_decoder dut_u (.clock(clock), .rst(rst), .in_valid(in_valid),
        .in_data(in_data), .in_first(in_first), .in_last(in_last), .in_ready(in_ready),
        .out_valid(out_valid), .out_char(out_char), .out_ready(out_ready), .busy(busy));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (!rst && out_valid && out_ready)
            got_q.push_back(out_char);
        out_ready <= stall_en ? 1'($random(seed)) : 1'b1;
    end

    // ----------------------------------------------------------------
    // Expected characters of one field
    // ----------------------------------------------------------------
    function automatic void expect_field(input byte_q_t b);
        int i;
        int cnt;
        logic [15:0] base;
        scheme_t sch;
        if (b[0] == 8'h80)
        begin
            for (i = 1; i + 1 < b.size(); i += 2)
            begin
                if ({b[i], b[i+1]} == 16'hFFFF)
                    break;
                exp_q.push_back('{{b[i], b[i+1]}, 1'b0, SCHEME_DIRECT});
            end
        end
        else if (b[0] == 8'h81 || b[0] == 8'h82)
        begin
            cnt = b[1];
            base = (b[0] == 8'h81) ? {1'b0, b[2], 7'h00} : {b[2], b[3]};
            sch = (b[0] == 8'h81) ? SCHEME_HALF8 : SCHEME_HALF16;
            for (i = (b[0] == 8'h81) ? 3 : 4; i < b.size() && cnt > 0; i++)
            begin
                cnt--;
                if (b[i][7])
                    exp_q.push_back('{base + {9'h000, b[i][6:0]}, 1'b0, sch});
                else
                    exp_q.push_back('{{9'h000, b[i][6:0]}, 1'b1, sch});
            end
        end
        else
            foreach (b[i])
                if (b[i] != 8'hFF)
                    exp_q.push_back('{{9'h000, b[i][6:0]}, 1'b1, SCHEME_DEFAULT});
    endfunction

    task automatic compare_char(input alpha_char_t g, input alpha_char_t e);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t char got %h expected %h", $time, g, e);
        end
    endtask

    task automatic compare_flag(input logic g, input logic e, input string what);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t %s got %b expected %b", $time, what, g, e);
        end
    endtask

    task automatic compare_count(input int g, input int e);
        checks++;
        if (g != e)
        begin
            fail_count++;
            $display("ERROR %0t char count got %0d expected %0d", $time, g, e);
        end
    endtask

    task automatic run_field(input byte_q_t b, input string name);
        int k;
        logic busy_seen;
        got_q.delete();
        exp_q.delete();
        expect_field(b);
        foreach (b[k])
            reader_u.q.push_back('{k == 0, k == b.size() - 1, b[k]});
        busy_seen = 1'b0;
        for (k = 0; k < 400; k++)
        begin
            @(negedge clock);
            busy_seen = busy_seen | busy;
            if (reader_u.q.size() == 0 && !in_valid && !out_valid && got_q.size() >= exp_q.size())
                break;
        end
        // Up to four buffered bytes may still drain after the reader goes idle
        repeat (6)
        begin
            @(negedge clock);
            busy_seen = busy_seen | busy;
        end
        compare_count(got_q.size(), exp_q.size());
        compare_flag(busy_seen, 1'b1, "busy during field");
        compare_flag(busy, 1'b0, "busy after field");
        foreach (exp_q[k])
            if (k < got_q.size())
                compare_char(got_q[k], exp_q[k]);
        $display("test %s done, %0d chars", name, exp_q.size());
    endtask

    task automatic run_hex(input logic [127:0] v, input int n, input string name);
        byte_q_t b;
        for (int k = 0; k < n; k++)
            b.push_back(v[8*(n-1-k) +: 8]);
        run_field(b, name);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        fail_count++;
        $display("ERROR %0t run did not complete", $time);
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        byte_q_t b;
        int s;
        int n;
        rst = 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        run_hex(128'h820505302D82D32D31, 9, "half16");
        run_hex(128'h8105135395A640FFFF, 9, "half8");
        run_hex(128'h8004100041FFFFFF, 8, "direct");
        run_hex(128'h8012345678FF, 6, "direct_odd");
        run_hex(128'h8100204141, 5, "count_zero");
        run_hex(128'h8202FF80FF0105, 7, "count_short");
        run_hex(128'h48656CFFFF, 5, "unmarked");
        stall_en <= 1'b1;
        for (int t = 0; t < 40; t++)
        begin
            b.delete();
            s = $unsigned($random(seed)) % 4;
            n = 2 + $unsigned($random(seed)) % 12;
            // One scheme per field; unmarked fields keep bytes below the markers
            for (int k = 0; k < n; k++)
                b.push_back(s == 0 ? 8'($random(seed)) & 8'h7F : 8'($random(seed)));
            if (s != 0)
                b[0] = 8'h80 + 8'(s - 1);
            if (s >= 2)
                b[1] = 8'($unsigned($random(seed)) % 10);
            // Counted schemes always carry their full pointer
            while (b.size() < s + 1)
                b.push_back(8'h30);
            run_field(b, "random");
        end
        tally_and_finish();
    end
endmodule // test_ucs2_alpha_field_decoder
